/* File: common/plc_pkg.sv */
// package: register map, field positions, reset values and types of the loop clock control
package plc_pkg;

  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] PLC_LOOP_CTRL_ADDR  = 8'h00;  // loop_control_reg
  localparam logic [7:0] PLC_BW_CTRL_ADDR    = 8'h04;  // bandwidth_control_reg
  localparam logic [7:0] PLC_MODE_ADDR       = 8'h08;  // stop/break/config bits
  localparam logic [7:0] PLC_IRQ_STAT_ADDR   = 8'h0C;  // sticky event status, w1c
  localparam logic [7:0] PLC_IRQ_MASK_ADDR   = 8'h10;  // event mask

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int PLC_LC_IE_BIT     = 7;  // loop_irq_enable
  localparam int PLC_LC_FLAG_BIT   = 6;  // loop_change_flag (read only)
  localparam int PLC_LC_PWR_BIT    = 5;  // loop_power_on
  localparam int PLC_LC_BSS_BIT    = 4;  // base_source_select
  localparam int PLC_BW_AUTO_BIT   = 7;  // automatic bandwidth control
  localparam int PLC_BW_LOCK_BIT   = 6;  // lock indicator (read only)
  localparam int PLC_MD_RUNSTOP_BIT = 0; // osc_run_in_stop
  localparam int PLC_MD_BREAK_CLEAR_ENABLE_BIT   = 1;  // break_clear_enable
  localparam int PLC_MD_STOP_BIT   = 8;  // stop state (read only)
  localparam int PLC_MD_BRK_BIT    = 9;  // break state (read only)
  localparam int PLC_EV_LOCK_BIT   = 0;  // event: lock changed
  localparam int PLC_EV_STOP_BIT   = 1;  // event: forced source clear on stop

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic       PLC_PWR_RST       = 1'b1;  // loop powered at reset
  localparam logic       PLC_BSS_RST       = 1'b0;
  localparam logic       PLC_IE_RST        = 1'b0;
  localparam logic       PLC_AUTO_RST      = 1'b0;
  localparam logic       PLC_BREAK_CLEAR_ENABLE_RST      = 1'b0;
  localparam logic       PLC_RUNSTOP_RST   = 1'b0;
  localparam logic [1:0] PLC_EV_RST        = 2'h0;
  localparam logic [1:0] PLC_HOLD_CYCLES   = 2'h3;  // stasis per source clock
  localparam logic [1:0] PLC_AXI_OKAY      = 2'h0;
  localparam logic [1:0] PLC_AXI_SLVERR    = 2'h2;
  localparam int         PLC_EV_W          = 2;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic stop_req;   // stop instruction executed, level while stopped
    logic wait_req;   // wait instruction, no effect on this block
    logic brk_state;  // debug break state
  } plc_cpu_state_t;

  typedef enum logic [1:0] {
    PLC_SW_XTAL = 2'b00,  // crystal half rate drives output
    PLC_SW_OFFX = 2'b01,  // stasis, counting old source edges
    PLC_SW_VCO  = 2'b11,  // vco half rate drives output
    PLC_SW_OFFV = 2'b10   // stasis, counting vco source edges
  } plc_sw_state_t;

endpackage

/* File: src/plc_edge_det.sv */
// module: rising-edge pulse of a sampled source clock level
`timescale 1ns/1ps
module plc_edge_det
  import plc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic lvl_in,
  output logic      rise_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic last_ff;      // previous sample
  logic nxt_last;
  logic rise_ff;      // registered pulse
  logic nxt_rise;

  // next values
  always_comb begin
    nxt_last = lvl_in;
    nxt_rise = lvl_in & ~last_ff;
  end

  // registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      last_ff <= nxt_last;
      rise_ff <= nxt_rise;
    end
  end

  assign rise_out = rise_ff;
endmodule

/* File: src/plc_half_div.sv */
// module: divide-by-two of a source, advanced on each source edge pulse
`timescale 1ns/1ps
module plc_half_div
  import plc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic edge_in,
  input  wire logic run_in,
  output logic      half_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic half_ff;      // divided level
  logic nxt_half;

  // toggle on source edge, forced low when stopped
  always_comb begin
    nxt_half = half_ff;
    if (!run_in) begin
      nxt_half = 1'b0;
    end else if (edge_in) begin
      nxt_half = ~half_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= nxt_half;
    end
  end

  assign half_out = half_ff;
endmodule

/* File: src/plc_top.sv */
// module: loop lock interrupt, base clock selection and low-power control with AXI4-Lite
//
// Notes on behaviour
// - auto mode: lock change raises interrupt condition
// - flag sets regardless of enable bit
// - manual mode: no interrupt, flag reads zero
// - select bit routes vco half to output
// - vco selectable even when not locked
// - wait instruction changes nothing here
// - stop without osc: clocks, clockgen_irq low
// - stop on vco clears select bit
// - after stop crystal drives, select stays clear
// - stop with osc: loop off, crystal runs
// - break clear enabled: cleared flag stays cleared
// - break protect: control access keeps flag
// - control read outside break clears flag
// - select needs power; power kept while selected
// - output static three edges of each source into vco, three vco edges back except on stop
`timescale 1ns/1ps
module plc_top
  import plc_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           arst_n,
  // axi4-lite slave
  input  wire logic [7:0]     s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [7:0]     s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  // clock sources and analog loop status
  input  wire logic           osc_level,
  input  wire logic           vco_level,
  input  wire logic           loop_locked,
  input  wire plc_cpu_state_t cpu_state,
  // outputs
  output logic                crystal_clock,
  output logic                base_clock_out,
  output logic                clockgen_irq,
  output logic                loop_enable,
  output logic                osc_enable,
  output logic                event_irq
);
  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // a byte enable of lane 0 guards every control field
  function automatic logic lane0(input logic [3:0] strb);
    return strb[0];
  endfunction

  // w1c with set-wins priority
  function automatic logic [PLC_EV_W-1:0] w1c(input logic [PLC_EV_W-1:0] cur,
                                              input logic [PLC_EV_W-1:0] clr,
                                              input logic [PLC_EV_W-1:0] set);
    return (cur & ~clr) | set;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic                pwr_ff, nxt_pwr;           // loop_power_on
  logic                bss_ff, nxt_bss;           // base_source_select
  logic                ie_ff, nxt_ie;             // loop_irq_enable
  logic                flag_ff, nxt_flag;         // loop_change_flag
  logic                auto_ff, nxt_auto;         // automatic bandwidth
  logic                runstop_ff, nxt_runstop;   // osc_run_in_stop
  logic                break_clear_enable_ff, nxt_break_clear_enable;         // break_clear_enable
  logic                lock_ff, nxt_lock;         // lock as last seen
  logic [PLC_EV_W-1:0] ev_ff, nxt_ev;             // sticky events
  logic [PLC_EV_W-1:0] mask_ff, nxt_mask;         // event mask
  logic                stop_ff, nxt_stop;         // previous stop level
  // bus
  logic                aw_ff, nxt_aw;             // address held
  logic [7:0]          awa_ff, nxt_awa;
  logic                w_ff, nxt_w;               // data held
  logic [31:0]         wd_ff, nxt_wd;
  logic [3:0]          ws_ff, nxt_ws;
  logic                bv_ff, nxt_bv;
  logic [1:0]          br_ff, nxt_br;
  logic                rv_ff, nxt_rv;
  logic [31:0]         rd_ff, nxt_rd;
  logic [1:0]          rr_ff, nxt_rr;
  // outputs
  logic                xclk_ff, nxt_xclk;
  logic                out_ff, nxt_out;
  logic                irq_ff, nxt_irq;
  logic                loopen_ff, nxt_loopen;
  logic                oscen_ff, nxt_oscen;
  logic                evirq_ff, nxt_evirq;
  // switch sequencer
  plc_sw_state_t       sw_ff, nxt_sw;
  logic [1:0]          cnt_ff, nxt_cnt;

  // ------------------------------------------------------------
  // source edge detection and halving
  // ------------------------------------------------------------
  logic osc_rise, vco_rise, xhalf, vhalf, osc_run, vco_run;

  // crystal stops only in stop mode without the run-in-stop option
  assign osc_run = ~(cpu_state.stop_req & ~runstop_ff);
  assign vco_run = pwr_ff & ~cpu_state.stop_req;

  plc_edge_det u_osc_edge (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .lvl_in   (osc_level),
    .rise_out (osc_rise)
  );
  plc_edge_det u_vco_edge (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .lvl_in   (vco_level),
    .rise_out (vco_rise)
  );
  plc_half_div u_osc_half (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .edge_in  (osc_rise),
    .run_in   (osc_run),
    .half_out (xhalf)
  );
  plc_half_div u_vco_half (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .edge_in  (vco_rise),
    .run_in   (vco_run),
    .half_out (vhalf)
  );

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic wr_go, rd_go, wr_lc, rd_lc, wr_bw, wr_md, wr_st, wr_mk, wr_ok, rd_ok;
  logic flag_vis;
  assign wr_go = aw_ff & w_ff & ~bv_ff;
  assign rd_go = s_axi_arvalid & ~rv_ff;
  assign wr_lc = wr_go & (awa_ff == PLC_LOOP_CTRL_ADDR) & lane0(ws_ff);
  assign wr_bw = wr_go & (awa_ff == PLC_BW_CTRL_ADDR) & lane0(ws_ff);
  assign wr_md = wr_go & (awa_ff == PLC_MODE_ADDR) & lane0(ws_ff);
  assign wr_st = wr_go & (awa_ff == PLC_IRQ_STAT_ADDR) & lane0(ws_ff);
  assign wr_mk = wr_go & (awa_ff == PLC_IRQ_MASK_ADDR) & lane0(ws_ff);
  assign rd_lc = rd_go & (s_axi_araddr == PLC_LOOP_CTRL_ADDR);
  assign wr_ok = (awa_ff == PLC_LOOP_CTRL_ADDR) | (awa_ff == PLC_BW_CTRL_ADDR) |
                 (awa_ff == PLC_MODE_ADDR) | (awa_ff == PLC_IRQ_STAT_ADDR) |
                 (awa_ff == PLC_IRQ_MASK_ADDR);
  assign rd_ok = (s_axi_araddr == PLC_LOOP_CTRL_ADDR) |
                 (s_axi_araddr == PLC_BW_CTRL_ADDR) |
                 (s_axi_araddr == PLC_MODE_ADDR) |
                 (s_axi_araddr == PLC_IRQ_STAT_ADDR) |
                 (s_axi_araddr == PLC_IRQ_MASK_ADDR);
  // flag shows only in automatic mode
  assign flag_vis = flag_ff & auto_ff;

  // ------------------------------------------------------------
  // axi channel handshakes, one write and one read at a time
  // ------------------------------------------------------------
  always_comb begin
    nxt_aw  = aw_ff;
    nxt_awa = awa_ff;
    nxt_w   = w_ff;
    nxt_wd  = wd_ff;
    nxt_ws  = ws_ff;
    nxt_bv  = bv_ff;
    nxt_br  = br_ff;
    nxt_rv  = rv_ff;
    nxt_rd  = rd_ff;
    nxt_rr  = rr_ff;
    // take address and data in either order
    if (s_axi_awvalid & ~aw_ff) begin
      nxt_aw  = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid & ~w_ff) begin
      nxt_w  = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
    end
    // response once both are held
    if (wr_go) begin
      nxt_bv = 1'b1;
      nxt_br = wr_ok ? PLC_AXI_OKAY : PLC_AXI_SLVERR;
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
    end else if (bv_ff & s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    // read answer one cycle after the address is taken
    if (rd_go) begin
      nxt_rv = 1'b1;
      nxt_rr = rd_ok ? PLC_AXI_OKAY : PLC_AXI_SLVERR;
      nxt_rd = 32'h0000_0000;
      case (s_axi_araddr)
        PLC_LOOP_CTRL_ADDR: begin
          nxt_rd[PLC_LC_IE_BIT]   = ie_ff;
          nxt_rd[PLC_LC_FLAG_BIT] = flag_vis;
          nxt_rd[PLC_LC_PWR_BIT]  = pwr_ff;
          nxt_rd[PLC_LC_BSS_BIT]  = bss_ff;
        end
        PLC_BW_CTRL_ADDR: begin
          nxt_rd[PLC_BW_AUTO_BIT] = auto_ff;
          nxt_rd[PLC_BW_LOCK_BIT] = lock_ff & auto_ff;
        end
        PLC_MODE_ADDR: begin
          nxt_rd[PLC_MD_RUNSTOP_BIT] = runstop_ff;
          nxt_rd[PLC_MD_BREAK_CLEAR_ENABLE_BIT]    = break_clear_enable_ff;
          nxt_rd[PLC_MD_STOP_BIT]    = cpu_state.stop_req;
          nxt_rd[PLC_MD_BRK_BIT]     = cpu_state.brk_state;
        end
        PLC_IRQ_STAT_ADDR: nxt_rd[PLC_EV_W-1:0] = ev_ff;
        PLC_IRQ_MASK_ADDR: nxt_rd[PLC_EV_W-1:0] = mask_ff;
        default:           nxt_rd = 32'h0000_0000;  // unmapped reads zero
      endcase
    end else if (rv_ff & s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // control bits, flag and events
  // ------------------------------------------------------------
  logic lock_chg, stop_rise, flag_clr, prot;
  // protected when in break and clearing is not enabled
  assign prot      = cpu_state.brk_state & ~break_clear_enable_ff;
  assign lock_chg  = auto_ff & (loop_locked != lock_ff);
  assign stop_rise = cpu_state.stop_req & ~stop_ff;
  // read or read-modify-write of the control register clears
  assign flag_clr  = (rd_lc | wr_lc) & ~prot;

  always_comb begin
    nxt_pwr     = pwr_ff;
    nxt_bss     = bss_ff;
    nxt_ie      = ie_ff;
    nxt_auto    = auto_ff;
    nxt_runstop = runstop_ff;
    nxt_break_clear_enable    = break_clear_enable_ff;
    nxt_mask    = mask_ff;
    nxt_stop    = cpu_state.stop_req;
    nxt_lock    = loop_locked;
    // wait_req is deliberately not read here
    if (wr_lc) begin
      nxt_ie = wd_ff[PLC_LC_IE_BIT];
      // select may only be set with power on, independent of lock
      if (wd_ff[PLC_LC_BSS_BIT] & pwr_ff) begin
        nxt_bss = 1'b1;
      end else if (~wd_ff[PLC_LC_BSS_BIT]) begin
        nxt_bss = 1'b0;
      end
      // power may only drop while the crystal is selected
      if (wd_ff[PLC_LC_PWR_BIT] | bss_ff | nxt_bss) begin
        nxt_pwr = pwr_ff | wd_ff[PLC_LC_PWR_BIT];
      end else begin
        nxt_pwr = 1'b0;
      end
    end
    if (wr_bw) begin
      nxt_auto = wd_ff[PLC_BW_AUTO_BIT];
    end
    if (wr_md) begin
      nxt_runstop = wd_ff[PLC_MD_RUNSTOP_BIT];
      nxt_break_clear_enable    = wd_ff[PLC_MD_BREAK_CLEAR_ENABLE_BIT];
    end
    if (wr_mk) begin
      nxt_mask = wd_ff[PLC_EV_W-1:0];
    end
    // stop on the vco forces the crystal and keeps it selected
    if (stop_rise & bss_ff) begin
      nxt_bss = 1'b0;
    end
    // flag: lock change sets regardless of enable, set beats clear
    nxt_flag = flag_ff;
    if (flag_clr) begin
      nxt_flag = 1'b0;
    end
    if (lock_chg) begin
      nxt_flag = 1'b1;
    end
    nxt_ev = w1c(ev_ff, wr_st ? wd_ff[PLC_EV_W-1:0] : PLC_EV_RST,
                 {stop_rise & bss_ff, lock_chg});
  end

  // ------------------------------------------------------------
  // base clock switch with stasis
  // ------------------------------------------------------------
  always_comb begin
    nxt_sw  = sw_ff;
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    case (sw_ff)
      PLC_SW_XTAL: begin
        nxt_out = xhalf;
        if (bss_ff) begin
          nxt_sw  = PLC_SW_OFFX;
          nxt_cnt = 2'h0;
        end
      end
      PLC_SW_OFFX: begin
        // output frozen while the crystal is seen three times
        if (osc_rise & (cnt_ff != PLC_HOLD_CYCLES)) begin
          nxt_cnt = cnt_ff + 2'h1;
        end
        if (cnt_ff == PLC_HOLD_CYCLES) begin
          nxt_sw  = bss_ff ? PLC_SW_OFFV : PLC_SW_XTAL;
          nxt_cnt = 2'h0;
        end
      end
      PLC_SW_OFFV: begin
        if (vco_rise & (cnt_ff != PLC_HOLD_CYCLES)) begin
          nxt_cnt = cnt_ff + 2'h1;
        end
        if (cnt_ff == PLC_HOLD_CYCLES) begin
          nxt_sw  = bss_ff ? PLC_SW_VCO : PLC_SW_XTAL;
          nxt_cnt = 2'h0;
        end
        if (~bss_ff & cpu_state.stop_req) begin
          nxt_sw = PLC_SW_XTAL;  // forced back on stop
        end
      end
      PLC_SW_VCO: begin
        nxt_out = vhalf;
        if (~bss_ff) begin
          // stop clears select: go straight to crystal
          nxt_sw  = cpu_state.stop_req ? PLC_SW_XTAL : PLC_SW_OFFV;
          nxt_cnt = 2'h0;
        end
      end
      default: begin
        nxt_sw  = PLC_SW_XTAL;
        nxt_cnt = 2'h0;
      end
    endcase
    if (~osc_run) begin
      nxt_out = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_comb begin
    nxt_xclk   = osc_run ? osc_level : 1'b0;
    nxt_loopen = vco_run;
    nxt_oscen  = osc_run;
    // interrupt follows flag and enable, silent in manual mode or in stop without osc_run_in_stop
    nxt_irq    = flag_vis & ie_ff & osc_run;
    nxt_evirq  = |(nxt_ev & mask_ff);
  end

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_ff     <= PLC_PWR_RST;
      bss_ff     <= PLC_BSS_RST;
      ie_ff      <= PLC_IE_RST;
      flag_ff    <= 1'b0;
      auto_ff    <= PLC_AUTO_RST;
      runstop_ff <= PLC_RUNSTOP_RST;
      break_clear_enable_ff    <= PLC_BREAK_CLEAR_ENABLE_RST;
      lock_ff    <= 1'b0;
      ev_ff      <= PLC_EV_RST;
      mask_ff    <= PLC_EV_RST;
      stop_ff    <= 1'b0;
      aw_ff      <= 1'b0;
      awa_ff     <= 8'h00;
      w_ff       <= 1'b0;
      wd_ff      <= 32'h0000_0000;
      ws_ff      <= 4'h0;
      bv_ff      <= 1'b0;
      br_ff      <= PLC_AXI_OKAY;
      rv_ff      <= 1'b0;
      rd_ff      <= 32'h0000_0000;
      rr_ff      <= PLC_AXI_OKAY;
      xclk_ff    <= 1'b0;
      out_ff     <= 1'b0;
      irq_ff     <= 1'b0;
      loopen_ff  <= 1'b0;
      oscen_ff   <= 1'b0;
      evirq_ff   <= 1'b0;
      sw_ff      <= PLC_SW_XTAL;
      cnt_ff     <= 2'h0;
    end else begin
      pwr_ff     <= nxt_pwr;
      bss_ff     <= nxt_bss;
      ie_ff      <= nxt_ie;
      flag_ff    <= nxt_flag;
      auto_ff    <= nxt_auto;
      runstop_ff <= nxt_runstop;
      break_clear_enable_ff    <= nxt_break_clear_enable;
      lock_ff    <= nxt_lock;
      ev_ff      <= nxt_ev;
      mask_ff    <= nxt_mask;
      stop_ff    <= nxt_stop;
      aw_ff      <= nxt_aw;
      awa_ff     <= nxt_awa;
      w_ff       <= nxt_w;
      wd_ff      <= nxt_wd;
      ws_ff      <= nxt_ws;
      bv_ff      <= nxt_bv;
      br_ff      <= nxt_br;
      rv_ff      <= nxt_rv;
      rd_ff      <= nxt_rd;
      rr_ff      <= nxt_rr;
      xclk_ff    <= nxt_xclk;
      out_ff     <= nxt_out;
      irq_ff     <= nxt_irq;
      loopen_ff  <= nxt_loopen;
      oscen_ff   <= nxt_oscen;
      evirq_ff   <= nxt_evirq;
      sw_ff      <= nxt_sw;
      cnt_ff     <= nxt_cnt;
    end
  end

  // ready is low while a beat is held, so the master's valid waits
  assign s_axi_awready  = ~aw_ff;
  assign s_axi_wready   = ~w_ff;
  assign s_axi_bvalid   = bv_ff;
  assign s_axi_bresp    = br_ff;
  assign s_axi_arready  = ~rv_ff;
  assign s_axi_rvalid   = rv_ff;
  assign s_axi_rdata    = rd_ff;
  assign s_axi_rresp    = rr_ff;
  assign crystal_clock  = xclk_ff;
  assign base_clock_out = out_ff;
  assign clockgen_irq   = irq_ff;
  assign loop_enable    = loopen_ff;
  assign osc_enable     = oscen_ff;
  assign event_irq      = evirq_ff;
endmodule

/* File: tb/plc_top_assertions.sv */
// checker: port timing relations of the loop clock control
`timescale 1ns/1ps
module plc_top_assertions
  import plc_pkg::*;
(
  input logic           sys_clk,
  input logic           arst_n,
  input logic           s_axi_awvalid,
  input logic           s_axi_awready,
  input logic           s_axi_wvalid,
  input logic           s_axi_wready,
  input logic           s_axi_bvalid,
  input logic           s_axi_bready,
  input logic [1:0]     s_axi_bresp,
  input logic           s_axi_arvalid,
  input logic           s_axi_arready,
  input logic           s_axi_rvalid,
  input logic           s_axi_rready,
  input logic [31:0]    s_axi_rdata,
  input logic           osc_level,
  input plc_cpu_state_t cpu_state,
  input logic           crystal_clock,
  input logic           base_clock_out,
  input logic           clockgen_irq,
  input logic           loop_enable,
  input logic           osc_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // a stopped oscillator leaves every clock and the irq low
  off_low_a:
    assert property (!osc_enable [*2] |-> !crystal_clock && !base_clock_out && !clockgen_irq)
      else $error("output active while oscillator off");
  // a running oscillator reaches the crystal output one cycle late
  xtal_follow_a:
    assert property (osc_enable [*2] |-> crystal_clock == $past(osc_level))
      else $error("crystal output does not follow oscillator");
  // stop always powers the loop down
  stop_loop_a:
    assert property (cpu_state.stop_req [*3] |-> !loop_enable)
      else $error("loop still enabled in stop");
  wr_resp_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");
  b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  r_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
  rd_resp_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
  rd_block_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read repeated");
endmodule
bind plc_top plc_top_assertions u_chk (.sys_clk, .arst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .osc_level, .cpu_state,
  .crystal_clock, .base_clock_out, .clockgen_irq, .loop_enable, .osc_enable);

/* File: tb/tb_top.sv */
// testbench: registers, lock irq, source select, stop and break
`timescale 1ns/1ps
module tb_top;
  import plc_pkg::*;
  logic sys_clk = 0, arst_n = 0, osc_level = 0, vco_level = 0, loop_locked = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, crystal_clock, base_clock_out, clockgen_irq, loop_enable;
  logic osc_enable, event_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  plc_cpu_state_t cpu_state = '0;
  int error_cnt = 0, checked = 0, cyc = 0;
  plc_top u_dut (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_level, .vco_level, .loop_locked,
    .cpu_state, .crystal_clock, .base_clock_out, .clockgen_irq, .loop_enable,
    .osc_enable, .event_irq);
  always #20 sys_clk = ~sys_clk;
  // sources: crystal toggles every 2 cycles, vco every 3; hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc % 2 == 1) osc_level <= ~osc_level;
    if (cyc % 3 == 2) vco_level <= ~vco_level;
    if (cyc > 20000) begin
      error_cnt++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    fork
      begin do @(posedge sys_clk); while (!s_axi_awready); s_axi_awvalid <= 0; end
      begin do @(posedge sys_clk); while (!s_axi_wready); s_axi_wvalid <= 0; end
    join
    while (!s_axi_bvalid) @(posedge sys_clk);
    chk(32'(s_axi_bresp), 32'(PLC_AXI_OKAY));
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  // base output edges in 48 cycles, after the switch stasis
  task automatic rate(input int lo, input int hi);
    logic p;
    int n = 0;
    repeat (40) @(posedge sys_clk);
    p = base_clock_out;
    repeat (48) begin
      @(posedge sys_clk);
      if (base_clock_out !== p) n++;
      p = base_clock_out;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic t_sel;
    rd(8'h00, 32'h20, PLC_AXI_OKAY);
    rd(8'h14, 32'h0, PLC_AXI_SLVERR);
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h10);
    rd(8'h00, 32'h0, PLC_AXI_OKAY);
    wr(8'h00, 32'h20);
    wr(8'h00, 32'h30);
    rd(8'h00, 32'h30, PLC_AXI_OKAY);
    rate(7, 9);
    wr(8'h00, 32'h10);
    rd(8'h00, 32'h30, PLC_AXI_OKAY);
    $display("t_sel done");
  endtask
  task automatic t_stop;
    cpu_state.stop_req <= 1;
    repeat (4) @(posedge sys_clk);
    chk(32'({crystal_clock, base_clock_out, clockgen_irq, loop_enable, osc_enable}), 0);
    cpu_state.stop_req <= 0;
    rd(8'h00, 32'h20, PLC_AXI_OKAY);
    rd(8'h0C, 32'h2, PLC_AXI_OKAY);
    rate(11, 13);
    wr(8'h08, 32'h1);
    cpu_state.stop_req <= 1;
    repeat (4) @(posedge sys_clk);
    chk(32'({loop_enable, osc_enable}), 32'h1);
    cpu_state <= 3'b010;
    repeat (4) @(posedge sys_clk);
    chk(32'({loop_enable, osc_enable}), 32'h3);
    rd(8'h00, 32'h20, PLC_AXI_OKAY);
    cpu_state <= '0;
    wr(8'h0C, 32'h3);
    $display("t_stop done");
  endtask
  task automatic t_lock;
    wr(8'h04, 32'h80);
    wr(8'h00, 32'hA0);
    loop_locked <= 1;
    repeat (3) @(posedge sys_clk);
    chk(32'(clockgen_irq), 32'h1);
    rd(8'h04, 32'hC0, PLC_AXI_OKAY);
    rd(8'h00, 32'hE0, PLC_AXI_OKAY);
    repeat (3) @(posedge sys_clk);
    chk(32'(clockgen_irq), 32'h0);
    wr(8'h00, 32'h20);
    loop_locked <= 0;
    repeat (3) @(posedge sys_clk);
    chk(32'({clockgen_irq, event_irq}), 32'h0);
    rd(8'h00, 32'h60, PLC_AXI_OKAY);
    wr(8'h10, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(32'(event_irq), 32'h1);
    wr(8'h0C, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(32'(event_irq), 32'h0);
    loop_locked <= 1;
    repeat (3) @(posedge sys_clk);
    wr(8'h04, 32'h0);
    rd(8'h00, 32'h20, PLC_AXI_OKAY);
    $display("t_lock done");
  endtask
  task automatic t_brk;
    wr(8'h04, 32'h80);
    cpu_state.brk_state <= 1;
    loop_locked <= 0;
    repeat (3) @(posedge sys_clk);
    rd(8'h00, 32'h60, PLC_AXI_OKAY);
    rd(8'h00, 32'h60, PLC_AXI_OKAY);
    wr(8'h08, 32'h2);
    rd(8'h00, 32'h60, PLC_AXI_OKAY);
    rd(8'h00, 32'h20, PLC_AXI_OKAY);
    cpu_state.brk_state <= 0;
    rd(8'h00, 32'h20, PLC_AXI_OKAY);
    $display("t_brk done");
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1;
    t_sel;
    t_stop;
    t_lock;
    t_brk;
    test_done;
  end
endmodule
